// [include/dram_ctrl_pkg.sv]
// Shared constants and types for the low latency DRAM controller
package dram_ctrl_pkg;

    // ==========================================================
    // Memory command bus
    localparam int ADDR_W = 21;
    localparam int BANK_W = 3;
    localparam int NUM_BANKS = 8;
    localparam int CMD_W = 3;

    // Command code bit positions: {select_n, write_n, refresh_n}
    localparam int CMD_CS_BIT = 2;
    localparam int CMD_WE_BIT = 1;
    localparam int CMD_REF_BIT = 0;

    // Command codes
    localparam logic [CMD_W-1:0] CMD_IDLE = 3'h7;
    localparam logic [CMD_W-1:0] CMD_MRS = 3'h0;
    localparam logic [CMD_W-1:0] CMD_READ = 3'h3;
    localparam logic [CMD_W-1:0] CMD_WRITE = 3'h1;
    localparam logic [CMD_W-1:0] CMD_AUTO_REFRESH_CMD = 3'h2;

    // Reset values of the address and bank lines
    localparam logic [ADDR_W-1:0] ADDR_RST = 21'h0_0000;
    localparam logic [BANK_W-1:0] BANK_RST = 3'h0;

    // ==========================================================
    // Address/command clock sources
    localparam logic [1:0] AC_CLK_SYS = 2'h0;
    localparam logic [1:0] AC_CLK_WRITE = 2'h1;
    localparam logic [1:0] AC_CLK_DED = 2'h2;

    // ==========================================================
    // Limits and counters
    localparam int MAX_MCLK = 4;
    localparam int INIT_CNT_W = 16;

    // Power-up sequencer states
    typedef enum logic [1:0] {st_wait, st_mrs, st_ref, st_run} init_state_t;

endpackage : dram_ctrl_pkg

// [rtl/low_latency_dram_controller.sv]
// Low latency DRAM controller: control logic and datapath
//
`timescale 1ns/1ps
module low_latency_dram_controller #(
    parameter int BITS_PER_GRP = 9,
    parameter int NUM_GRP = 4,
    parameter int GRP_PER_DEV = 2,
    parameter int NUM_MCLK = 2,
    parameter bit CIO_TYPE = 1'b1,
    parameter bit STROBE_MODE = 1'b1,
    parameter int AC_PIPE = 0,
    parameter int WR_LAT = 1,
    parameter int RD_PIPE = 0,
    parameter bit DUAL_AC = 1'b0,
    parameter logic [1:0] AC_CLK_SEL = dram_ctrl_pkg::AC_CLK_SYS,
    parameter bit AC_FALL = 1'b0,
    parameter logic [dram_ctrl_pkg::ADDR_W-1:0] MODE_VAL = 21'h0_0000,
    parameter int INIT_WAIT_CYC = 64
) (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    // Local request side
    input wire logic req_read_in,
    input wire logic req_write_in,
    input wire logic req_refresh_in,
    input wire logic [dram_ctrl_pkg::ADDR_W-1:0] req_addr_in,
    input wire logic [dram_ctrl_pkg::BANK_W-1:0] req_bank_in,
    input wire logic [2*BITS_PER_GRP*NUM_GRP-1:0] wdata_in,
    input wire logic [2*(NUM_GRP/GRP_PER_DEV)-1:0] wmask_in,
    output logic local_ready_out,
    output logic init_done_out,
    // Local read side
    output logic [2*BITS_PER_GRP*NUM_GRP-1:0] rdata_out,
    output logic [NUM_GRP/GRP_PER_DEV-1:0] rvalid_out,
    output logic [NUM_GRP/GRP_PER_DEV-1:0] capture_clk_out,
    // Memory clocks
    output logic [NUM_MCLK-1:0] mem_clk_out,
    // Default command bus
    output logic mem_cs_n_0_out,
    output logic mem_we_n_0_out,
    output logic mem_ref_n_0_out,
    output logic [dram_ctrl_pkg::ADDR_W-1:0] mem_addr_0_out,
    output logic [dram_ctrl_pkg::BANK_W-1:0] mem_bank_0_out,
    // Second command bus
    output logic mem_cs_n_1_out,
    output logic mem_we_n_1_out,
    output logic mem_ref_n_1_out,
    output logic [dram_ctrl_pkg::ADDR_W-1:0] mem_addr_1_out,
    output logic [dram_ctrl_pkg::BANK_W-1:0] mem_bank_1_out,
    // Memory write data and mask
    output logic [BITS_PER_GRP*NUM_GRP-1:0] mem_dq_out,
    output logic mem_dq_oe_out,
    output logic [BITS_PER_GRP*NUM_GRP-1:0] mem_d_out,
    output logic [NUM_GRP/GRP_PER_DEV-1:0] mem_write_mask_out,
    // Memory read data, valid and strobes
    input wire logic [BITS_PER_GRP*NUM_GRP-1:0] mem_dq_in,
    input wire logic [BITS_PER_GRP*NUM_GRP-1:0] mem_q_in,
    input wire logic [NUM_GRP/GRP_PER_DEV-1:0] mem_valid_in,
    input wire logic [NUM_GRP-1:0] mem_read_strobe_in,
    input wire logic ext_capture_clk_in
);

    // ==========================================================
    // Derived widths and command word layout
    localparam int AW = dram_ctrl_pkg::ADDR_W;
    localparam int BW = dram_ctrl_pkg::BANK_W;
    localparam int CW = dram_ctrl_pkg::CMD_W;
    localparam int DW = BITS_PER_GRP * NUM_GRP;
    localparam int LW = 2 * DW;
    localparam int ND = NUM_GRP / GRP_PER_DEV;
    localparam int GW = 2 * BITS_PER_GRP;
    localparam int DEVW = GRP_PER_DEV * GW;
    localparam int PDEP = AC_PIPE + WR_LAT + 1;
    localparam int O_ADDR = BW;
    localparam int O_CMD = O_ADDR + AW;
    localparam int O_DATA = O_CMD + CW;
    localparam int O_MASK = O_DATA + LW;
    localparam int O_WR = O_MASK + 2 * ND;
    localparam int PW = O_WR + 1;
    localparam logic [PW-1:0] IDLE_WORD = {{(1 + 2 * ND + LW){1'b0}},
        dram_ctrl_pkg::CMD_IDLE, dram_ctrl_pkg::ADDR_RST,
        dram_ctrl_pkg::BANK_RST};
    // Write clock lags by half a memory cycle, so it flips the slot
    localparam bit AC_SLOT = AC_FALL ^
        (AC_CLK_SEL == dram_ctrl_pkg::AC_CLK_WRITE);
    localparam int CNT_W = dram_ctrl_pkg::INIT_CNT_W;

    // ==========================================================
    // Memory cycle phase and memory clocks
    logic phase_ff;
    logic [NUM_MCLK-1:0] mclk_ff;

    // Phase 1 is the rising half, phase 0 the falling half
    wire logic cyc_en = phase_ff;
    wire logic ac_load = (phase_ff == AC_SLOT);

    // Double rate clock registers: high in the rising half
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            phase_ff <= 1'b0;
            mclk_ff <= '0;
        end else begin
            phase_ff <= ~phase_ff;
            mclk_ff <= {NUM_MCLK{~phase_ff}};
        end
    end

    assign mem_clk_out = mclk_ff;

    // ==========================================================
    // Power-up sequencer
    dram_ctrl_pkg::init_state_t st_ff;
    dram_ctrl_pkg::init_state_t nxt_st;
    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] nxt_cnt;
    logic ready_ff;
    logic done_ff;

    wire logic wait_end = (cnt_ff == CNT_W'(INIT_WAIT_CYC - 1));
    wire logic ref_end = (cnt_ff == CNT_W'(dram_ctrl_pkg::NUM_BANKS - 1));
    wire logic run_mode = (st_ff == dram_ctrl_pkg::st_run);
    wire logic in_mrs = (st_ff == dram_ctrl_pkg::st_mrs);
    wire logic in_ref = (st_ff == dram_ctrl_pkg::st_ref);

    // Wait, one mode set, one refresh per bank, then run
    always_comb begin
        nxt_st = st_ff;
        nxt_cnt = cnt_ff + CNT_W'(1);
        case (st_ff)
            dram_ctrl_pkg::st_wait: begin
                if (wait_end) begin
                    nxt_st = dram_ctrl_pkg::st_mrs;
                    nxt_cnt = '0;
                end
            end
            dram_ctrl_pkg::st_mrs: begin
                nxt_st = dram_ctrl_pkg::st_ref;
                nxt_cnt = '0;
            end
            dram_ctrl_pkg::st_ref: begin
                if (ref_end) begin
                    nxt_st = dram_ctrl_pkg::st_run;
                    nxt_cnt = '0;
                end
            end
            dram_ctrl_pkg::st_run: begin
                nxt_cnt = cnt_ff;
            end
            default: begin
                nxt_st = dram_ctrl_pkg::st_wait;
                nxt_cnt = '0;
            end
        endcase
    end

    // Sequencer steps once per memory cycle
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            st_ff <= dram_ctrl_pkg::st_wait;
            cnt_ff <= '0;
        end else if (cyc_en) begin
            st_ff <= nxt_st;
            cnt_ff <= nxt_cnt;
        end
    end

    // Ready only in run mode, in the rising half before a cycle edge
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            ready_ff <= 1'b0;
            done_ff <= 1'b0;
        end else begin
            ready_ff <= run_mode & ~phase_ff;
            done_ff <= run_mode;
        end
    end

    assign local_ready_out = ready_ff;
    assign init_done_out = done_ff;

    // ==========================================================
    // Request decode: read wins over write, write over refresh
    wire logic take_rd = ready_ff & req_read_in;
    wire logic take_wr = ready_ff & ~req_read_in & req_write_in;
    wire logic take_rf = ready_ff & ~req_read_in & ~req_write_in &
        req_refresh_in;
    wire logic take_ab = take_rd | take_wr;

    // Command code for the memory cycle now being issued
    wire logic [CW-1:0] new_cmd =
        in_mrs ? dram_ctrl_pkg::CMD_MRS :
        (in_ref | take_rf) ? dram_ctrl_pkg::CMD_AUTO_REFRESH_CMD :
        take_rd ? dram_ctrl_pkg::CMD_READ :
        take_wr ? dram_ctrl_pkg::CMD_WRITE :
        dram_ctrl_pkg::CMD_IDLE;

    // Mode value during mode set, request address for read or write
    wire logic [AW-1:0] new_addr = in_mrs ? MODE_VAL :
        (take_ab ? req_addr_in : dram_ctrl_pkg::ADDR_RST);

    // Bank count during init refresh, request bank for a taken request
    wire logic [BW-1:0] new_bank = in_ref ? cnt_ff[BW-1:0] :
        ((take_ab | take_rf) ? req_bank_in : dram_ctrl_pkg::BANK_RST);

    wire logic [PW-1:0] new_word = {take_wr, wmask_in, wdata_in,
        new_cmd, new_addr, new_bank};

    // ==========================================================
    // Command and write pipeline on the system clock
    logic [PW-1:0] apipe_ff [0:PDEP-1];

    // One shift per memory cycle moves both paths in step; data sits WR_LAT stages deeper
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            for (int i = 0; i < PDEP; i++) begin
                apipe_ff[i] <= IDLE_WORD;
            end
        end else if (cyc_en) begin
            apipe_ff[0] <= new_word;
            for (int i = 1; i < PDEP; i++) begin
                apipe_ff[i] <= apipe_ff[i-1];
            end
        end
    end

    // Command slot and, write latency later, the data slot
    wire logic [PW-1:0] cslot = apipe_ff[AC_PIPE];
    wire logic [PW-1:0] dslot = apipe_ff[AC_PIPE + WR_LAT];

    // ==========================================================
    // Address and command output registers
    logic [CW-1:0] cmd0_ff;
    logic [AW-1:0] addr0_ff;
    logic [BW-1:0] bank0_ff;
    logic [CW-1:0] cmd1_ff;
    logic [AW-1:0] addr1_ff;
    logic [BW-1:0] bank1_ff;

    // Launch in the selected half; the second bus copies the first
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            cmd0_ff <= dram_ctrl_pkg::CMD_IDLE;
            addr0_ff <= dram_ctrl_pkg::ADDR_RST;
            bank0_ff <= dram_ctrl_pkg::BANK_RST;
            cmd1_ff <= dram_ctrl_pkg::CMD_IDLE;
            addr1_ff <= dram_ctrl_pkg::ADDR_RST;
            bank1_ff <= dram_ctrl_pkg::BANK_RST;
        end else if (ac_load) begin
            cmd0_ff <= cslot[O_CMD +: CW];
            addr0_ff <= cslot[O_ADDR +: AW];
            bank0_ff <= cslot[0 +: BW];
            if (DUAL_AC) begin
                cmd1_ff <= cslot[O_CMD +: CW];
                addr1_ff <= cslot[O_ADDR +: AW];
                bank1_ff <= cslot[0 +: BW];
            end
        end
    end

    // Command lines from the registered codes
    assign mem_cs_n_0_out = cmd0_ff[dram_ctrl_pkg::CMD_CS_BIT];
    assign mem_we_n_0_out = cmd0_ff[dram_ctrl_pkg::CMD_WE_BIT];
    assign mem_ref_n_0_out = cmd0_ff[dram_ctrl_pkg::CMD_REF_BIT];
    assign mem_addr_0_out = addr0_ff;
    assign mem_bank_0_out = bank0_ff;
    assign mem_cs_n_1_out = cmd1_ff[dram_ctrl_pkg::CMD_CS_BIT];
    assign mem_we_n_1_out = cmd1_ff[dram_ctrl_pkg::CMD_WE_BIT];
    assign mem_ref_n_1_out = cmd1_ff[dram_ctrl_pkg::CMD_REF_BIT];
    assign mem_addr_1_out = addr1_ff;
    assign mem_bank_1_out = bank1_ff;

    // ==========================================================
    // Write data groups: low half in rising, high half in falling
    genvar g;
    generate
        for (g = 0; g < NUM_GRP; g++) begin : write_group
            logic [BITS_PER_GRP-1:0] dq_ff;

            // Double rate output register of one data group
            always_ff @(posedge core_clk_in) begin
                if (sys_rst_in) begin
                    dq_ff <= '0;
                end else begin
                    dq_ff <= phase_ff ?
                        dslot[O_DATA+g*GW+BITS_PER_GRP +: BITS_PER_GRP] :
                        dslot[O_DATA+g*GW +: BITS_PER_GRP];
                end
            end

            // Same register feeds either bus type
            assign mem_dq_out[g*BITS_PER_GRP +: BITS_PER_GRP] = dq_ff;
            assign mem_d_out[g*BITS_PER_GRP +: BITS_PER_GRP] = dq_ff;
        end
    endgenerate

    // ==========================================================
    // Mask group and data bus drive enable
    logic [ND-1:0] mask_ff;
    logic oe_ff;

    // Mask follows the data timing; enable only on a common bus
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            mask_ff <= '0;
            oe_ff <= 1'b0;
        end else begin
            mask_ff <= phase_ff ? dslot[O_MASK+ND +: ND] :
                dslot[O_MASK +: ND];
            oe_ff <= CIO_TYPE & dslot[O_WR];
        end
    end

    assign mem_write_mask_out = mask_ff;
    assign mem_dq_oe_out = oe_ff;

    // ==========================================================
    // Read input synchronisers
    wire logic [DW-1:0] rd_bus = CIO_TYPE ? mem_dq_in : mem_q_in;
    logic [DW-1:0] rsync1_ff;
    logic [DW-1:0] rsync2_ff;
    logic [ND-1:0] vsync1_ff;
    logic [ND-1:0] vsync2_ff;

    // Two stages before any logic looks at pins
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            rsync1_ff <= '0;
            rsync2_ff <= '0;
            vsync1_ff <= '0;
            vsync2_ff <= '0;
        end else begin
            rsync1_ff <= rd_bus;
            rsync2_ff <= rsync1_ff;
            vsync1_ff <= mem_valid_in;
            vsync2_ff <= vsync1_ff;
        end
    end

    // ==========================================================
    // Read capture groups
    wire logic [LW-1:0] grp_word;
    wire logic [NUM_GRP-1:0] grp_rise;
    wire logic [NUM_GRP-1:0] grp_fall;
    wire logic [NUM_GRP-1:0] grp_lvl;

    generate
        for (g = 0; g < NUM_GRP; g++) begin : read_group
            // Own strobe in strobe mode, shared clock otherwise
            wire logic src = STROBE_MODE ? mem_read_strobe_in[g] :
                ext_capture_clk_in;
            logic [2:0] ssh_ff;
            logic [BITS_PER_GRP-1:0] lo_ff;
            logic [BITS_PER_GRP-1:0] hi_ff;

            // Sync stages, then capture on each detected edge
            always_ff @(posedge core_clk_in) begin
                if (sys_rst_in) begin
                    ssh_ff <= '0;
                    lo_ff <= '0;
                    hi_ff <= '0;
                end else begin
                    ssh_ff <= {ssh_ff[1:0], src};
                    if (grp_rise[g]) begin
                        lo_ff <= rsync2_ff[g*BITS_PER_GRP +: BITS_PER_GRP];
                    end
                    if (grp_fall[g]) begin
                        hi_ff <= rsync2_ff[g*BITS_PER_GRP +: BITS_PER_GRP];
                    end
                end
            end

            // Edge detect on the second and third stages only
            assign grp_rise[g] = ssh_ff[1] & ~ssh_ff[2];
            assign grp_fall[g] = ~ssh_ff[1] & ssh_ff[2];
            assign grp_lvl[g] = ssh_ff[2];
            assign grp_word[g*GW +: GW] = {hi_ff, lo_ff};
        end
    endgenerate

    // ==========================================================
    // Per device valid group, retiming and read pipeline
    genvar d;
    genvar s;
    generate
        for (d = 0; d < ND; d++) begin : device_read
            localparam int FG = d * GRP_PER_DEV;
            logic qv_ff;
            logic evt_ff;
            logic cclk_ff;
            logic rv_ff;
            logic [DEVW-1:0] rd_ff;
            wire logic [DEVW+1:0] rp [0:RD_PIPE];

            // Event, valid and device data travel together
            assign rp[0] = {evt_ff, qv_ff, grp_word[d*DEVW +: DEVW]};

            for (s = 0; s < RD_PIPE; s++) begin : read_pipe
                logic [DEVW+1:0] stg_ff;

                // One stage per system clock tick
                always_ff @(posedge core_clk_in) begin
                    if (sys_rst_in) begin
                        stg_ff <= '0;
                    end else begin
                        stg_ff <= rp[s];
                    end
                end

                assign rp[s+1] = stg_ff;
            end

            // Valid on first strobe rise; word taken after its fall
            always_ff @(posedge core_clk_in) begin
                if (sys_rst_in) begin
                    qv_ff <= 1'b0;
                    evt_ff <= 1'b0;
                    cclk_ff <= 1'b0;
                    rv_ff <= 1'b0;
                    rd_ff <= '0;
                end else begin
                    if (grp_rise[FG]) begin
                        qv_ff <= vsync2_ff[d];
                    end
                    evt_ff <= grp_fall[FG];
                    cclk_ff <= grp_lvl[FG];
                    rv_ff <= rp[RD_PIPE][DEVW+1] & rp[RD_PIPE][DEVW];
                    if (rp[RD_PIPE][DEVW+1]) begin
                        rd_ff <= rp[RD_PIPE][DEVW-1:0];
                    end
                end
            end

            assign rdata_out[d*DEVW +: DEVW] = rd_ff;
            assign rvalid_out[d] = rv_ff;
            assign capture_clk_out[d] = cclk_ff;
        end
    endgenerate

endmodule : low_latency_dram_controller

// [tb/dram_ctrl_properties.sv]
// Checker on the controller ports, bound into the controller module
`timescale 1ns/1ps
module dram_ctrl_properties #(
    parameter logic [20:0] MODE_VAL = 21'h0_0000,
    parameter bit DUAL_AC = 1'b0
) (
    // Clock, reset and local side
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    input wire logic req_read_in,
    input wire logic req_write_in,
    input wire logic req_refresh_in,
    input wire logic [20:0] req_addr_in,
    input wire logic [2:0] req_bank_in,
    input wire logic local_ready_out,
    input wire logic init_done_out,
    // Memory side
    input wire logic [1:0] mem_clk_out,
    input wire logic mem_cs_n_0_out,
    input wire logic mem_we_n_0_out,
    input wire logic mem_ref_n_0_out,
    input wire logic [20:0] mem_addr_0_out,
    input wire logic [2:0] mem_bank_0_out,
    input wire logic mem_cs_n_1_out,
    input wire logic mem_we_n_1_out,
    input wire logic mem_ref_n_1_out,
    input wire logic [20:0] mem_addr_1_out,
    input wire logic [2:0] mem_bank_1_out,
    input wire logic mem_dq_oe_out
);
    // Command lines as one code
    wire logic [2:0] cmd = {mem_cs_n_0_out, mem_we_n_0_out, mem_ref_n_0_out};
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (sys_rst_in);
    // ==========================================================
    // Properties
    property p_init_first;
        local_ready_out |-> init_done_out;
    endproperty
    a_init_first: assert property (p_init_first)
        else $error("early ready");
    property p_mrs_val;
        cmd == dram_ctrl_pkg::CMD_MRS |-> mem_addr_0_out == MODE_VAL;
    endproperty
    a_mrs_val: assert property (p_mrs_val)
        else $error("mode value");
    property p_wr_take;
        local_ready_out && req_write_in && !req_read_in |-> ##2
            cmd == dram_ctrl_pkg::CMD_WRITE
            && mem_addr_0_out == $past(req_addr_in, 2);
    endproperty
    a_wr_take: assert property (p_wr_take)
        else $error("write cmd");
    property p_rd_first;
        local_ready_out && req_read_in |-> ##2
            cmd == dram_ctrl_pkg::CMD_READ
            && mem_bank_0_out == $past(req_bank_in, 2);
    endproperty
    a_rd_first: assert property (p_rd_first)
        else $error("read cmd");
    property p_ref_take;
        local_ready_out && req_refresh_in && !req_read_in
            && !req_write_in |-> ##2
            cmd == dram_ctrl_pkg::CMD_AUTO_REFRESH_CMD
            && mem_bank_0_out == $past(req_bank_in, 2);
    endproperty
    a_ref_take: assert property (p_ref_take)
        else $error("refresh cmd");
    property p_cmd_hold;
        $fell(mem_cs_n_0_out) |=> $stable(cmd) && $stable(mem_addr_0_out);
    endproperty
    a_cmd_hold: assert property (p_cmd_hold)
        else $error("cmd too short");
    property p_dual;
        DUAL_AC |-> {mem_cs_n_1_out, mem_we_n_1_out, mem_ref_n_1_out} == cmd
            && mem_addr_1_out == mem_addr_0_out
            && mem_bank_1_out == mem_bank_0_out;
    endproperty
    a_dual: assert property (p_dual)
        else $error("second bus differs");
    property p_wr_beats;
        $rose(mem_dq_oe_out) |-> mem_clk_out[0]
            ##1 mem_dq_oe_out && !mem_clk_out[0];
    endproperty
    a_wr_beats: assert property (p_wr_beats)
        else $error("write beats");
endmodule : dram_ctrl_properties

bind low_latency_dram_controller dram_ctrl_properties #(
    .MODE_VAL(MODE_VAL),
    .DUAL_AC(DUAL_AC)
) dram_ctrl_properties_inst (
    .core_clk_in, .sys_rst_in, .req_read_in, .req_write_in, .req_refresh_in,
    .req_addr_in, .req_bank_in, .local_ready_out, .init_done_out, .mem_clk_out,
    .mem_cs_n_0_out, .mem_we_n_0_out, .mem_ref_n_0_out, .mem_addr_0_out,
    .mem_bank_0_out, .mem_cs_n_1_out, .mem_we_n_1_out, .mem_ref_n_1_out,
    .mem_addr_1_out, .mem_bank_1_out, .mem_dq_oe_out
);

// [tb/dram_mem_model.sv]
// Memory device model answering reads with strobes, valid and data
`timescale 1ns/1ps
module dram_mem_model (
    // Clock and command inputs
    input wire logic clk_in,
    input wire logic cs_n_in,
    input wire logic we_n_in,
    input wire logic ref_n_in,
    input wire logic [20:0] addr_in,
    // Read return outputs
    output logic [3:0] strobe_out,
    output logic [1:0] valid_out,
    output logic [35:0] dq_out
);
    logic [35:0] rise;
    // Strobes stand still between bursts; released bus shows the rising beat again
    initial begin
        strobe_out = 4'h0;
        valid_out = 2'h0;
        dq_out = 36'h0_0000_0000;
        forever begin
            @(posedge clk_in);
            if (!cs_n_in && we_n_in && ref_n_in) begin
                rise = {2{addr_in[17:0]}};
                repeat (2) @(posedge clk_in);
                dq_out <= rise;
                valid_out <= 2'h3;
                @(posedge clk_in);
                strobe_out <= 4'hf;
                repeat (4) @(posedge clk_in);
                dq_out <= ~rise;
                strobe_out <= 4'h0;
                repeat (4) @(posedge clk_in);
                dq_out <= rise;
                valid_out <= 2'h0;
            end
        end
    end
endmodule : dram_mem_model

// [tb/low_latency_dram_controller_test.sv]
// Testbench: init, refused request, back to back traffic, read return
`timescale 1ns/1ps
module low_latency_dram_controller_test;
    localparam logic [20:0] MODE = 21'h1_2345;
    localparam logic [71:0] WD = 72'h12_3456_789a_bcde_f012;
    logic clk, rst, rd, wr, rf, rdy, done, cs, we, rn, oe, mp;
    logic [20:0] ad, ao;
    logic [2:0] bk, bo;
    logic [71:0] wd, rdat;
    logic [3:0] wm, stb;
    logic [1:0] rv, vld, mk, mclk, cc;
    logic [35:0] dq, mdq, dd;
    logic [26:0] cq[$];
    logic [37:0] dqq[$];
    int fails, cmp_count, n, ncc;
    // Clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    low_latency_dram_controller #(.DUAL_AC(1'b1), .MODE_VAL(MODE),
        .INIT_WAIT_CYC(2)) low_latency_dram_controller_inst (
        .core_clk_in(clk), .sys_rst_in(rst), .req_read_in(rd),
        .req_write_in(wr), .req_refresh_in(rf), .req_addr_in(ad),
        .req_bank_in(bk), .wdata_in(wd), .wmask_in(wm), .local_ready_out(rdy),
        .init_done_out(done), .rdata_out(rdat), .rvalid_out(rv),
        .capture_clk_out(cc), .mem_clk_out(mclk), .mem_cs_n_0_out(cs),
        .mem_we_n_0_out(we), .mem_ref_n_0_out(rn), .mem_addr_0_out(ao),
        .mem_bank_0_out(bo), .mem_cs_n_1_out(), .mem_we_n_1_out(),
        .mem_ref_n_1_out(), .mem_addr_1_out(), .mem_bank_1_out(),
        .mem_dq_out(dq), .mem_dq_oe_out(oe), .mem_d_out(dd),
        .mem_write_mask_out(mk), .mem_dq_in(mdq), .mem_q_in(36'h0_0000_0000),
        .mem_valid_in(vld), .mem_read_strobe_in(stb),
        .ext_capture_clk_in(1'b0));
    dram_mem_model dram_mem_model_inst (.clk_in(clk), .cs_n_in(cs),
        .we_n_in(we), .ref_n_in(rn), .addr_in(ao), .strobe_out(stb),
        .valid_out(vld), .dq_out(mdq));
    // Records commands at memory clock rise and every driven data beat
    always @(posedge clk) begin
        if (mclk[0] && !mp && !cs) cq.push_back({cs, we, rn, ao, bo});
        if (oe) dqq.push_back({mk, dq});
        if (oe) check(dd, dq);
        if (cc == 2'h3) ncc++;
        mp <= mclk[0];
    end
    task automatic check(input logic [71:0] seen, input logic [71:0] want);
        cmp_count++;
        if (seen !== want) begin
            fails++;
            $display("unexpected at %0t: got %h want %h", $time, seen, want);
        end
    endtask : check
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : give_verdict
    task automatic guard(input int k);
        if (k >= 3000) begin
            fails++;
            $display("unexpected at %0t: wait ran out", $time);
            give_verdict();
        end
    endtask : guard
    // Falling beat in upper half, rising beat in lower half of each group
    function automatic logic [71:0] pack(input logic [71:0] fr);
        for (int g = 0; g < 4; g++) begin
            pack[18*g +: 9] = fr[9*g +: 9];
            pack[18*g+9 +: 9] = fr[36+9*g +: 9];
        end
    endfunction : pack
    // One request; off selects a cycle where ready is low
    task automatic issue(input logic [2:0] k, input logic [20:0] a,
        input logic [2:0] b, input logic off);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (!(done === 1'b1 && rdy === off) && n < 3000);
        guard(n);
        @(posedge clk);
        {rd, wr, rf} <= k;
        ad <= a;
        bk <= b;
        @(posedge clk);
        {rd, wr, rf} <= 3'h0;
    endtask : issue
    initial begin
        {rd, wr, rf, ad, bk} = '0;
        wd = WD;
        wm = 4'h9;
        rst = 1'b1;
        repeat (2) @(posedge clk);
        @(negedge clk);
        check(cs, 1'b1);
        @(posedge clk);
        rst <= 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 3000) begin
            @(negedge clk);
            n++;
        end
        guard(n);
        repeat (4) @(negedge clk);
        check(cq.size(), 9);
        check(cq[0][26:3], {dram_ctrl_pkg::CMD_MRS, MODE});
        for (int i = 1; i < 9; i++) begin
            check({cq[i][26:24], cq[i][2:0]},
                {dram_ctrl_pkg::CMD_AUTO_REFRESH_CMD, 3'(i - 1)});
        end
        cq.delete();
        $display("test init done");
        issue(3'h2, 21'h0_0abc, 3'h1, 1'b1);
        repeat (8) @(posedge clk);
        check(cq.size(), 0);
        $display("test refused done");
        issue(3'h2, 21'h1_5a5a, 3'h6, 1'b0);
        issue(3'h1, 21'h0_0000, 3'h5, 1'b0);
        issue(3'h6, 21'h0_c3a5, 3'h2, 1'b0);
        n = 0;
        while (rv === 2'h0 && n < 3000) begin
            @(negedge clk);
            n++;
        end
        guard(n);
        check(rv, 2'h3);
        check(rdat,
            pack({~{2{18'h0_c3a5}}, {2{18'h0_c3a5}}}));
        check(ncc, 4);
        check(cq.size(), 3);
        check(cq[0], {dram_ctrl_pkg::CMD_WRITE, 21'h1_5a5a, 3'h6});
        check({cq[1][26:24], cq[1][2:0]},
            {dram_ctrl_pkg::CMD_AUTO_REFRESH_CMD, 3'h5});
        check(cq[2], {dram_ctrl_pkg::CMD_READ, 21'h0_c3a5, 3'h2});
        check(dqq.size(), 2);
        check(pack({dqq[1][35:0], dqq[0][35:0]}), WD);
        check({dqq[1][37:36], dqq[0][37:36]}, 4'h9);
        $display("test traffic done");
        give_verdict();
    end
endmodule : low_latency_dram_controller_test
